// ### src/pcs_consts.svh
// Constants of the instruction pointer sequencer
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PTR_W 13
`define PCS_STACK_DEPTH 16
`define PCS_RESET_VEC 13'h0000
`define PCS_EXT_VEC 13'h0004
`define PCS_T0_VEC 13'h0008
`define PCS_T1_VEC 13'h000C
`define PCS_LOW_INDEX 8'h06
`define PCS_ADDR_LOW 8'h18
`define PCS_ADDR_STATUS 8'h1C
`define PCS_ADDR_CTRL 8'h20
`define PCS_CTRL_RESET 1'h1
`define PCS_JUMP_LSB 0
`endif

// ### src/pcs_pkg.sv
// Types of the instruction pointer sequencer
package pcs_pkg;
    typedef enum logic [1:0] {
        PCS_PH1 = 2'b00,
        PCS_PH2 = 2'b01,
        PCS_PH3 = 2'b10,
        PCS_PH4 = 2'b11
    } pcs_phase_t;

    typedef struct packed {
        pcs_phase_t phase;
    } pcs_phase_state_t;

    typedef struct packed {
        logic [12:0] ptr;
        logic [15:0][12:0] stack;
        logic [3:0] sp;
        logic [4:0] depth;
        logic exec_valid;
        logic [15:0] exec_word;
        logic low_pend;
        logic [7:0] low_data;
        logic run;
        logic irq_ack;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pcs_state_t;
endpackage

// ### src/pcs_phase_gen.sv
// Four phase divider of the system clock
`timescale 1ns/1ps
`default_nettype none
module pcs_phase_gen
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    output pcs_pkg::pcs_phase_t phase_out
);
    import pcs_pkg::*;

    pcs_phase_state_t s;
    pcs_phase_state_t next_s;

    // Step through the four phases in turn
    always_comb
    begin
        next_s = s;
        unique case (s.phase)
            PCS_PH1: next_s.phase = PCS_PH2;
            PCS_PH2: next_s.phase = PCS_PH3;
            PCS_PH3: next_s.phase = PCS_PH4;
            PCS_PH4: next_s.phase = PCS_PH1;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '{phase: PCS_PH1};
        else
            s <= next_s;
    end

    assign phase_out = s.phase;
endmodule
`default_nettype wire

// ### src/pcs_sequencer.sv
// Instruction pointer sequencer with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_sequencer
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Program memory
    output logic [12:0] imem_addr_out,
    input wire logic [15:0] imem_data_in,
    // Decoder side
    output pcs_pkg::pcs_phase_t phase_out,
    output logic exec_valid_out,
    output logic [15:0] exec_word_out,
    input wire logic jump_in,
    input wire logic call_in,
    input wire logic ret_in,
    input wire logic skip_in,
    // Interrupt side
    input wire logic irq_ext_in,
    input wire logic irq_t0_in,
    input wire logic irq_t1_in,
    output logic irq_ack_out
);
    import pcs_pkg::*;

    pcs_state_t s;
    pcs_state_t next_s;
    pcs_phase_t phase;
    logic cyc_end;
    logic instr_xfer;
    logic irq_req;
    logic irq_take;
    logic normal;
    logic apb_acc;
    logic [12:0] top;
    logic [12:0] vec;

    // ------------------------------------------------
    // Phase generation
    // ------------------------------------------------
    pcs_phase_gen u_phase (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .phase_out(phase)
    );

    // Pointer plus one within the program space
    function automatic logic [12:0] inc_ptr(input logic [12:0] p);
        inc_ptr = p + 13'h0001;
    endfunction

    // ------------------------------------------------
    // Event decode
    // ------------------------------------------------
    assign cyc_end = (phase == PCS_PH4);
    assign instr_xfer = s.exec_valid & (jump_in | call_in | ret_in | skip_in);
    assign irq_req = irq_ext_in | irq_t0_in | irq_t1_in;
    // Full stack holds off the interrupt until a return frees a level
    assign irq_take = cyc_end & s.run & ~instr_xfer & ~s.low_pend & irq_req
        & (s.depth != 5'h10);
    assign normal = cyc_end & s.run & ~instr_xfer & ~s.low_pend & ~irq_take;
    assign apb_acc = psel_in & penable_in & ~s.pready;
    assign top = s.stack[s.sp - 4'h1];
    // External first, then first and second event counter
    assign vec = irq_ext_in ? `PCS_EXT_VEC :
        (irq_t0_in ? `PCS_T0_VEC : `PCS_T1_VEC);

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.irq_ack = 1'h0;
        next_s.pready = 1'h0;
        next_s.pslverr = 1'h0;
        // Close of an instruction cycle moves the pointer
        if (cyc_end && s.run)
        begin
            next_s.exec_valid = 1'h0;
            if (instr_xfer && ret_in)
            begin
                next_s.ptr = top;
                next_s.sp = s.sp - 4'h1;
                if (s.depth != 5'h00)
                    next_s.depth = s.depth - 5'h01;
            end
            else if (instr_xfer && (call_in || jump_in))
            begin
                if (call_in)
                begin
                    next_s.stack[s.sp] = s.ptr;
                    next_s.sp = s.sp + 4'h1;
                    if (s.depth != 5'h10)
                        next_s.depth = s.depth + 5'h01;
                end
                next_s.ptr = s.exec_word[12:`PCS_JUMP_LSB];
            end
            else if (instr_xfer)
                next_s.ptr = inc_ptr(s.ptr);
            else if (s.low_pend)
            begin
                next_s.ptr = {s.ptr[12:8], s.low_data};
                next_s.low_pend = 1'h0;
            end
            else if (irq_take)
            begin
                next_s.stack[s.sp] = s.ptr;
                next_s.sp = s.sp + 4'h1;
                next_s.depth = s.depth + 5'h01;
                next_s.ptr = vec;
                next_s.irq_ack = 1'h1;
            end
            else
            begin
                next_s.exec_word = imem_data_in;
                next_s.exec_valid = 1'h1;
                next_s.ptr = inc_ptr(s.ptr);
            end
        end
        else if (cyc_end)
            next_s.exec_valid = 1'h0;
        // APB access, one wait state; a new write beats the clear above
        if (apb_acc)
        begin
            next_s.pready = 1'h1;
            next_s.prdata = 32'h0000_0000;
            unique case (paddr_in)
                `PCS_ADDR_LOW:
                begin
                    next_s.prdata = {24'h00_0000, s.ptr[7:0]};
                    if (pwrite_in)
                    begin
                        next_s.low_pend = 1'h1;
                        next_s.low_data = pwdata_in[7:0];
                    end
                end
                `PCS_ADDR_STATUS:
                    next_s.prdata = {10'h000, s.depth, s.exec_valid,
                        s.ptr[12:0], 3'h0};
                `PCS_ADDR_CTRL:
                begin
                    next_s.prdata = {31'h0000_0000, s.run};
                    if (pwrite_in)
                        next_s.run = pwdata_in[0];
                end
                default:
                    next_s.pslverr = 1'h1;
            endcase
        end
    end

    // ------------------------------------------------
    // State register
    // ------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s <= '0;
            s.ptr <= `PCS_RESET_VEC;
            s.run <= `PCS_CTRL_RESET;
        end
        else
            s <= next_s;
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign imem_addr_out = s.ptr;
    assign phase_out = phase;
    assign exec_valid_out = s.exec_valid;
    assign exec_word_out = s.exec_word;
    assign irq_ack_out = s.irq_ack;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Sampled reset keeps the release edge out, phase is still held there
    property p_phase_seq;
        rst_n_in && phase == PCS_PH1 |=> phase == PCS_PH2
            ##1 phase == PCS_PH3 ##1 phase == PCS_PH4 ##1 phase == PCS_PH1;
    endproperty
    a_phase_seq: assert property (p_phase_seq)
        else $error("phase order broken");

    property p_pipe;
        normal |=> exec_valid_out && exec_word_out == $past(imem_data_in);
    endproperty
    a_pipe: assert property (p_pipe)
        else $error("fetched word not passed to execute");

    property p_dummy;
        cyc_end && s.run && instr_xfer |=> !exec_valid_out [*4];
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("no dummy cycle after transfer");

    property p_inc;
        normal |=> imem_addr_out == $past(imem_addr_out) + 13'h0001;
    endproperty
    a_inc: assert property (p_inc)
        else $error("pointer not advanced by one");

    property p_skip;
        cyc_end && s.run && s.exec_valid && skip_in && !jump_in && !call_in
            && !ret_in |=> imem_addr_out == $past(imem_addr_out) + 13'h0001
            ##3 !exec_valid_out;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip target wrong");

    property p_low;
        cyc_end && s.run && !instr_xfer && s.low_pend |=>
            imem_addr_out == {$past(s.ptr[12:8]), $past(s.low_data)};
    endproperty
    a_low: assert property (p_low)
        else $error("low byte jump left the page");

    property p_jump;
        cyc_end && s.run && s.exec_valid && jump_in && !ret_in |=>
            imem_addr_out == $past(exec_word_out[12:0]);
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target not from word");

    property p_ext;
        irq_take && irq_ext_in |=> imem_addr_out == 13'h0004 && irq_ack_out;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external vector wrong");

    property p_t0;
        irq_take && !irq_ext_in && irq_t0_in |=> imem_addr_out == 13'h0008;
    endproperty
    a_t0: assert property (p_t0)
        else $error("first counter vector wrong");

    property p_t1;
        irq_take && !irq_ext_in && !irq_t0_in |=> imem_addr_out == 13'h000C;
    endproperty
    a_t1: assert property (p_t1)
        else $error("second counter vector wrong");

    property p_ret;
        cyc_end && s.run && s.exec_valid && ret_in |=>
            imem_addr_out == $past(top);
    endproperty
    a_ret: assert property (p_ret)
        else $error("return did not restore pointer");
endmodule
`default_nettype wire

// ### test/pcs_imem_model.sv
// Program memory model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module pcs_imem_model
(
    input wire logic [12:0] imem_addr_in,
    output logic [15:0] imem_data_out
);
    // Word differs from its address in many bits, so wrong fetches show
    assign imem_data_out = {3'h5, imem_addr_in ^ 13'h1A5A};
endmodule
`default_nettype wire

// ### test/tb_program_counter_sequencer.sv
// Self-checking bench of the instruction pointer sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
`define CHK(x, y) begin checked++; if ((x) !== (y)) begin mismatches++; \
    $display("wrong value at %0t: compare failed", $time); end end
module tb_program_counter_sequencer;
    import pcs_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] dec = 4'h0;
    logic [2:0] irq = 3'h0;
    logic [31:0] prdata, r, d;
    logic pready, pslverr, exec_valid, irq_ack, e;
    logic [12:0] imem_addr, a, b;
    logic [15:0] imem_data, exec_word;
    pcs_phase_t phase;
    int mismatches = 0;
    int checked = 0;
    int seed = 25;
    int n;
    logic [2:0] irqs [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    logic [12:0] vecs [4] = '{`PCS_EXT_VEC, `PCS_T0_VEC, `PCS_T1_VEC,
        `PCS_T0_VEC};

    // -------------------------------------------------------------
    // Clock and units under test
    // -------------------------------------------------------------
    // Clock of 25 ns period
    always #12.5 core_clk_in = ~core_clk_in;

    pcs_sequencer pcs_sequencer_inst (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .imem_addr_out(imem_addr), .imem_data_in(imem_data),
        .phase_out(phase), .exec_valid_out(exec_valid),
        .exec_word_out(exec_word), .jump_in(dec[1]), .call_in(dec[2]),
        .ret_in(dec[3]), .skip_in(dec[0]), .irq_ext_in(irq[0]),
        .irq_t0_in(irq[1]), .irq_t1_in(irq[2]), .irq_ack_out(irq_ack));

    pcs_imem_model pcs_imem_model_inst (.imem_addr_in(imem_addr),
        .imem_data_out(imem_data));

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [15:0] mem(input logic [12:0] x);
        return {3'h5, x ^ 13'h1A5A};
    endfunction

    // Run to the middle of the first phase of the next cycle
    task automatic cyc();
        n = 0;
        do
        begin
            @(negedge core_clk_in);
            n++;
        end
        while (phase !== PCS_PH1);
    endtask

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] wd);
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do
            @(posedge core_clk_in);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One plain cycle: pointer advances, fetched word executes
    task automatic step();
        a = imem_addr;
        cyc();
        `CHK(n, 4)
        `CHK(imem_addr, a + 13'h1)
        `CHK(exec_word, mem(a))
    endtask

    // Decoder verdict k (0 skip, 1 jump, 2 call, 3 return) to target x
    task automatic xfer(input int k, input logic [12:0] x);
        @(posedge core_clk_in);
        dec <= 4'h1 << k;
        cyc();
        `CHK(imem_addr, x)
        `CHK(exec_valid, 1'b0)
        @(posedge core_clk_in);
        dec <= 4'h0;
        cyc();
        `CHK(exec_word, mem(x))
        `CHK(exec_valid, 1'b1)
    endtask

    task automatic stop_test();
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    // Main sequence
    initial
    begin
        repeat (2) @(posedge core_clk_in);
        `CHK(imem_addr, 13'h0000)
        rst_n_in <= 1'b1;
        // Phase holds its reset value one clock more after release
        cyc();
        cyc();
        `CHK(exec_word, mem(13'h0000))
        repeat (3 + ($random(seed) & 3)) step();
        xfer(1, exec_word[12:0]);
        step();
        xfer(0, imem_addr + 13'h1);
        a = imem_addr;
        b = a;
        xfer(2, exec_word[12:0]);
        step();
        xfer(3, b);
        d = $random(seed);
        b = imem_addr;
        apb(1'b1, `PCS_ADDR_LOW, d);
        cyc();
        `CHK(exec_valid, 1'b0)
        `CHK(imem_addr, {b[12:8], d[7:0]})
        cyc();
        a = imem_addr;
        apb(1'b0, `PCS_ADDR_LOW, 32'h0);
        `CHK(r, {24'h00_0000, a[7:0]})
        apb(1'b1, 8'h44, d);
        `CHK(e, 1'b1)
        `CHK(r, 32'h0000_0000)
        for (int k = 0; k < 4; k++)
        begin
            cyc();
            step();
            a = imem_addr;
            @(posedge core_clk_in);
            irq <= irqs[k];
            cyc();
            `CHK(imem_addr, vecs[k])
            `CHK(irq_ack, 1'b1)
            @(posedge core_clk_in);
            irq <= 3'h0;
            cyc();
            `CHK(exec_valid, 1'b1)
            `CHK(exec_word, mem(vecs[k]))
            xfer(3, a);
        end
        // Sequencing frozen by the run bit, then status read back
        b = imem_addr;
        apb(1'b1, `PCS_ADDR_CTRL, 32'h0000_0000);
        cyc();
        cyc();
        `CHK(imem_addr, b)
        `CHK(exec_valid, 1'b0)
        apb(1'b0, `PCS_ADDR_STATUS, 32'h0000_0000);
        `CHK(r, {10'h000, 5'h00, 1'b0, b, 3'h0})
        apb(1'b1, `PCS_ADDR_CTRL, 32'h0000_0001);
        cyc();
        step();
        // Reset in mid-run, then a clean restart from address zero
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        @(negedge core_clk_in);
        `CHK(imem_addr, 13'h0000)
        `CHK(phase, PCS_PH1)
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        cyc();
        cyc();
        `CHK(exec_word, mem(13'h0000))
        `CHK(imem_addr, 13'h0001)
        stop_test();
    end

    // Watchdog against a hang
    initial
    begin
        #(25 * 5000);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
